// File: rtl/halt_wake_ctrl.sv
// Halt mode entry, wake-up sequencing, warm-up and reset stretching
`timescale 1ns/1ps
`default_nettype none
module halt_wake_ctrl
	import halt_wake_pkg::*;
#(
	parameter int WARMUP_CYCLES = WARM_CYCLES,
	parameter int WARM_W        = 15
) (
	// System clock and power-on reset
	input  wire logic        CLK_SYS,
	input  wire logic        RESET,
	// Asynchronous pins
	input  wire logic        NMI_N,
	input  wire logic        INT_N,
	input  wire logic        RESET_PIN_N_IN,
	// Open-drain reset pin drive
	output var  logic        RESET_PIN_OUT,
	output var  logic        RESET_PIN_OE_N,
	// CPU side
	input  wire logic        HALT_FETCH,
	input  wire logic        CFG_WR,
	input  wire cfg_s        CFG_IN,
	output var  cfg_s        CFG,
	output var  logic        CPU_RESET,
	output var  logic        HALTED,
	output var  logic        START_FETCH,
	output var  logic        SERVICE_NMI,
	output var  logic        SERVICE_INT,
	output var  logic [15:0] START_ADDR,
	// Clock gating enables
	output var  clk_en_s     CLK_EN
);
	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		S_RUN    = 7'b000_0001,
		S_LOOP   = 7'b000_0010,
		S_IDLE   = 7'b000_0100,
		S_STOP   = 7'b000_1000,
		S_WARM   = 7'b001_0000,
		S_NOP    = 7'b010_0000,
		S_RST    = 7'b100_0000
	} state_e;

	localparam logic [WARM_W-1:0] WARM_LOAD = WARM_W'(WARMUP_CYCLES - 1);
	localparam logic [4:0]        STRETCH   = 5'(RST_STRETCH);
	localparam logic [1:0]        T4        = 2'(T4_INDEX);
	localparam logic [1:0]        DUMMY_END = 2'(DUMMY_T_STATES - 1);

	state_e            state;
	state_e            next_state;
	logic [1:0]        t_cnt;
	logic [1:0]        dummy_cnt;
	logic              in_dummy;
	logic [WARM_W-1:0] warm_cnt;
	logic [1:0]        low_cnt;
	logic [4:0]        stretch_cnt;
	logic              nmi_pend;
	logic              nmi_prev;
	logic [2:0]        pins;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// Three pins through one filtered synchroniser bank
	sync_three #(.WIDTH(3), .INIT(32'h0000_0007)) u_sync (
		.clk      (CLK_SYS),
		.rst      (RESET),
		.async_in ({NMI_N, INT_N, RESET_PIN_N_IN}),
		.sync_out (pins)
	);
	wire nmi_n_s = pins[2];
	wire int_n_s = pins[1];
	wire rst_n_s = pins[0];

	// ----------------------------------------------------------------
	// Reset acceptance and stretching
	// ----------------------------------------------------------------
	// Driven pin reads back low, so stretching only starts on a fresh acceptance
	wire [1:0] low_need    = CFG.rstout_dis ? 2'(RST_MIN_NO_DRIVE - 1)
	                                        : 2'(RST_MIN_DRIVE - 1);
	wire       rst_accept  = !rst_n_s && (low_cnt >= low_need);
	wire       stretching  = stretch_cnt != 5'h00;
	wire       start_str   = rst_accept && !stretching && !CPU_RESET && !CFG.rstout_dis;
	wire       hold_reset  = rst_accept || stretching;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			low_cnt     <= 2'b00;
			stretch_cnt <= 5'h00;
		end else begin
			low_cnt     <= rst_n_s ? 2'b00 : (low_cnt == 2'b11 ? low_cnt : low_cnt + 2'b01);
			stretch_cnt <= start_str ? STRETCH : (stretching ? stretch_cnt - 5'h01 : 5'h00);
		end
	end

	// Configuration registers: defaults on either reset
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			CFG <= '{halt_mode: HALT_MODE_RESET, rstout_dis: RSTOUT_DIS_RESET};
		end else if (hold_reset) begin
			CFG <= '{halt_mode: HALT_MODE_RESET, rstout_dis: RSTOUT_DIS_RESET};
		end else if (CFG_WR) begin
			CFG <= CFG_IN;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt sampling
	// ----------------------------------------------------------------
	// NMI is edge latched and has no mask; a new edge beats the service clear
	wire nmi_edge   = nmi_prev && !nmi_n_s;
	wire at_t4      = (state == S_LOOP || state == S_NOP) && t_cnt == T4;
	wire take_nmi   = at_t4 && nmi_pend;
	wire take_int   = at_t4 && !nmi_pend && !int_n_s;
	wire accepted   = take_nmi || take_int;
	wire wake_req   = nmi_pend || !int_n_s;
	wire halt_again = (CFG.halt_mode == MODE_STOP) ? 1'b1 : 1'b0;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			nmi_prev <= 1'b1;
			nmi_pend <= 1'b0;
		end else begin
			nmi_prev <= nmi_n_s;
			nmi_pend <= nmi_edge || (nmi_pend && !take_nmi && !hold_reset);
		end
	end

	// ----------------------------------------------------------------
	// Halt state machine
	// ----------------------------------------------------------------
	// Next state from halt entry, wake requests and reset
	always_comb begin
		next_state = state;
		case (state)
			S_RUN: begin
				if (HALT_FETCH) begin
					if (CFG.halt_mode == MODE_RUN) next_state = S_LOOP;
					else if (halt_again) next_state = S_STOP;
					else next_state = S_IDLE;
				end
			end
			S_LOOP: begin
				if (accepted) next_state = S_RUN;
			end
			S_IDLE: begin
				if (wake_req) next_state = S_NOP;
			end
			S_STOP: begin
				if (wake_req) next_state = S_WARM;
			end
			S_WARM: begin
				if (warm_cnt == '0) next_state = S_NOP;
			end
			S_NOP: begin
				if (accepted) next_state = S_RUN;
				else if (t_cnt == T4) next_state = halt_again ? S_STOP : S_IDLE;
			end
			S_RST: begin
				if (in_dummy && dummy_cnt == DUMMY_END) next_state = S_RUN;
			end
			default: next_state = S_RUN;
		endcase
		if (hold_reset) next_state = S_RST;
	end

	// State, T-state counter and warm-up counter
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state    <= S_RST;
			t_cnt    <= 2'b00;
			warm_cnt <= '0;
		end else begin
			state    <= next_state;
			t_cnt    <= (next_state == state && (state == S_LOOP || state == S_NOP)) ? t_cnt + 2'b01 : 2'b00;
			warm_cnt <= (state == S_STOP) ? WARM_LOAD : (warm_cnt == '0 ? warm_cnt : warm_cnt - 1'b1);
		end
	end

	// Dummy T states after reset release; no warm-up on this path
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			in_dummy  <= 1'b0;
			dummy_cnt <= 2'b00;
		end else begin
			in_dummy  <= (state == S_RST) && !hold_reset && !(in_dummy && dummy_cnt == DUMMY_END);
			dummy_cnt <= in_dummy ? dummy_cnt + 2'b01 : 2'b00;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Enables change only on clock edges, so gated clocks get whole pulses
	wire idle_timer = (state == S_IDLE) && CFG.halt_mode == MODE_IDLE_TIMER;
	clk_en_s next_en;
	assign next_en.osc     = next_state != S_STOP;
	assign next_en.sys     = !(next_state inside {S_IDLE, S_STOP, S_WARM});
	assign next_en.clk_out = next_en.sys || (next_state == S_IDLE && CFG.halt_mode == MODE_IDLE_TIMER);
	assign next_en.timer   = next_en.clk_out;

	wire next_start = (state == S_RST) && next_state == S_RUN;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			CLK_EN         <= '{osc: 1'b1, clk_out: 1'b1, timer: 1'b1, sys: 1'b1};
			CPU_RESET      <= 1'b1;
			HALTED         <= 1'b0;
			START_FETCH    <= 1'b0;
			SERVICE_NMI    <= 1'b0;
			SERVICE_INT    <= 1'b0;
			START_ADDR     <= ADDR_RESET;
			RESET_PIN_OUT  <= 1'b0;
			RESET_PIN_OE_N <= 1'b1;
		end else begin
			CLK_EN         <= next_en;
			CPU_RESET      <= next_state == S_RST && !(state == S_RST && !hold_reset);
			HALTED         <= !(next_state inside {S_RUN, S_RST});
			START_FETCH    <= next_start || accepted;
			SERVICE_NMI    <= take_nmi;
			SERVICE_INT    <= take_int;
			START_ADDR     <= take_nmi ? ADDR_NMI : ADDR_RESET;
			RESET_PIN_OUT  <= 1'b0;
			RESET_PIN_OE_N <= !(start_str || (stretching && stretch_cnt != 5'h01));
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	property p_reset_fetch;
		$fell(CPU_RESET) |-> ##2 (START_FETCH && START_ADDR == ADDR_RESET);
	endproperty
	a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch timing wrong");

	property p_idle_wake;
		(state == S_IDLE && wake_req && !hold_reset) |=> ##1 (CLK_EN.sys && CLK_EN.clk_out);
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake did not start clocks");

	property p_nop_len;
		// A reset during the NOP ends it legally, so it aborts the check
		disable iff (RESET || hold_reset)
		$rose(state == S_NOP) && !hold_reset |-> (state == S_NOP && !accepted)[*3] ##1 (at_t4 || hold_reset);
	endproperty
	a_nop_len: assert property (p_nop_len) else $error("wake NOP not four T states");

	property p_rehalt;
		disable iff (RESET || hold_reset)
		(state == S_NOP && at_t4 && !accepted && !hold_reset) |=> ##1 !CLK_EN.sys;
	endproperty
	a_rehalt: assert property (p_rehalt) else $error("no re-halt after empty NOP");

	property p_int_level;
		// Service follows the sampled level at T4, both ways
		(at_t4 && !nmi_pend) |=> (SERVICE_INT == !$past(int_n_s));
	endproperty
	a_int_level: assert property (p_int_level) else $error("INT service disagrees with T4 level");

	property p_warm;
		disable iff (RESET || hold_reset)
		(state == S_STOP && wake_req && !hold_reset) |=> (!CLK_EN.sys throughout (state == S_WARM)[*8]);
	endproperty
	a_warm: assert property (p_warm) else $error("clock ran during warm-up");

	property p_stop_osc;
		(state == S_STOP) |=> (state == S_STOP) |-> !CLK_EN.osc && !CLK_EN.clk_out;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("clocks alive in stop");

	property p_stretch;
		$fell(RESET_PIN_OE_N) |-> !RESET_PIN_OE_N[*8] ##1 !RESET_PIN_OE_N[*8];
	endproperty
	a_stretch: assert property (p_stretch) else $error("reset drive shorter than sixteen");

	property p_nmi_vec;
		SERVICE_NMI |-> (START_ADDR == ADDR_NMI && START_FETCH && !SERVICE_INT);
	endproperty
	a_nmi_vec: assert property (p_nmi_vec) else $error("NMI vector wrong");

	property p_timer_idle;
		(idle_timer && $past(idle_timer)) |-> (CLK_EN.timer && CLK_EN.clk_out && !CLK_EN.sys);
	endproperty
	a_timer_idle: assert property (p_timer_idle) else $error("timer idle clocks wrong");

	c_stop_wake: cover property ((state == S_WARM) ##1 (state == S_NOP));
	c_nmi_loop: cover property ((state == S_LOOP) ##1 SERVICE_NMI);
	c_idle_rehalt: cover property ((state == S_NOP) ##1 (state == S_IDLE));
	c_stretch_done: cover property ($rose(RESET_PIN_OE_N));
endmodule
`default_nettype wire

// File: rtl/halt_wake_pkg.sv
// Package: constants and types for the halt and wake clock control
package halt_wake_pkg;

	// Halt mode select encodings
	localparam logic [1:0] MODE_IDLE_ALL   = 2'b00;       // idle_all_clocks_off
	localparam logic [1:0] MODE_IDLE_TIMER = 2'b01;       // idle_timer_alive
	localparam logic [1:0] MODE_STOP       = 2'b10;
	localparam logic [1:0] MODE_RUN        = 2'b11;

	// Configuration reset values
	localparam logic [1:0] HALT_MODE_RESET  = MODE_RUN;
	localparam logic       RSTOUT_DIS_RESET = 1'b0;       // mode_control_reg bit D3
	localparam int         RSTOUT_DIS_BIT   = 3;

	// Start addresses
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] ADDR_NMI   = 16'h0066;

	// Timing: one T state is one system clock
	localparam int CLK_PERIOD_PS    = 25_000;
	localparam int T4_INDEX         = 3;                  // T1..T4 counted 0..3
	localparam int DUMMY_T_STATES   = 2;
	localparam int RST_MIN_NO_DRIVE = 3;                  // reset output disabled
	localparam int RST_MIN_DRIVE    = 2;                  // reset output enabled
	localparam int RST_STRETCH      = 16;
	// Warm-up of 2^14 + 2.5 clock periods, held in half periods
	localparam int WARM_HALF_PERIODS = 2 * 16384 + 5;
	localparam int WARM_CYCLES       = (WARM_HALF_PERIODS + 1) / 2;  // rounded up

	// Clock enables driven to the gating cells
	typedef struct packed {
		logic osc;      // on-chip oscillator running
		logic clk_out;  // clock_output_pin enable
		logic timer;    // counter_timer_unit clock
		logic sys;      // internal system clock to CPU and peripherals
	} clk_en_s;

	// Configuration held in system control registers
	typedef struct packed {
		logic [1:0] halt_mode;
		logic       rstout_dis;
	} cfg_s;

endpackage

// File: rtl/sync_three.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sync_three
	import halt_wake_pkg::*;
#(
	parameter int       WIDTH = 1,
	parameter bit [31:0] INIT = '1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Asynchronous in, filtered out
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] st1;
	logic [WIDTH-1:0] st2;
	logic [WIDTH-1:0] st3;
	wire  [WIDTH-1:0] agree = ~(st2 ^ st3);

	// Stage one feeds only stage two; a change counts when two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			st1      <= INIT[WIDTH-1:0];
			st2      <= INIT[WIDTH-1:0];
			st3      <= INIT[WIDTH-1:0];
			sync_out <= INIT[WIDTH-1:0];
		end else begin
			st1      <= async_in;
			st2      <= st1;
			st3      <= st2;
			sync_out <= (agree & st3) | (~agree & sync_out);
		end
	end
endmodule
`default_nettype wire

// File: tb/halt_wake_ctrl_bench.sv
// Self-checking bench for the halt and wake clock control
`timescale 1ns/1ps
`default_nettype none
module halt_wake_ctrl_bench
	import halt_wake_pkg::*;
;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam int      W       = 40;    // Short warm-up keeps stop tests quick
	localparam int      LIMIT   = 3000;
	localparam clk_en_s EN_HALT [4] = '{4'h8, 4'hE, 4'h0, 4'hF};  // By halt mode
	// Driven by the bench at falling edges
	logic             CLK_SYS;
	logic             RESET;
	logic             HALT_FETCH;
	logic             CFG_WR;
	cfg_s             CFG_IN;
	// Driven by the partner model
	wire logic        NMI_N;
	wire logic        INT_N;
	wire logic        RESET_PIN_N_IN;
	// Driven by the design
	wire logic        RESET_PIN_OUT;
	wire logic        RESET_PIN_OE_N;
	wire cfg_s        CFG;
	wire logic        CPU_RESET;
	wire logic        HALTED;
	wire logic        START_FETCH;
	wire logic        SERVICE_NMI;
	wire logic        SERVICE_INT;
	wire logic [15:0] START_ADDR;
	wire clk_en_s     CLK_EN;
	int               n_mismatch = 0, checks_done = 0, cycles = 0;
	halt_wake_ctrl #(
		.WARMUP_CYCLES (W),
		.WARM_W        (15)
	) i_halt_wake_ctrl (
		.CLK_SYS        (CLK_SYS),
		.RESET          (RESET),
		.NMI_N          (NMI_N),
		.INT_N          (INT_N),
		.RESET_PIN_N_IN (RESET_PIN_N_IN),
		.RESET_PIN_OUT  (RESET_PIN_OUT),
		.RESET_PIN_OE_N (RESET_PIN_OE_N),
		.HALT_FETCH     (HALT_FETCH),
		.CFG_WR         (CFG_WR),
		.CFG_IN         (CFG_IN),
		.CFG            (CFG),
		.CPU_RESET      (CPU_RESET),
		.HALTED         (HALTED),
		.START_FETCH    (START_FETCH),
		.SERVICE_NMI    (SERVICE_NMI),
		.SERVICE_INT    (SERVICE_INT),
		.START_ADDR     (START_ADDR),
		.CLK_EN         (CLK_EN)
	);
	irq_reset_source i_irq_reset_source (
		.CLK_SYS     (CLK_SYS),
		.pin_drv     (RESET_PIN_OUT),
		.pin_oe_n    (RESET_PIN_OE_N),
		.nmi_n       (NMI_N),
		.int_n       (INT_N),
		.reset_pin_n (RESET_PIN_N_IN)
	);
	// 40 MHz clock
	initial begin
		CLK_SYS = 1'h0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	// Hang guard: a stuck wait ends the run as a failure
	always @(posedge CLK_SYS) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Compare and wait helpers
	// ----------------------------------------
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_en(input string nm, input clk_en_s e, input clk_en_s g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return START_FETCH;
			1: return CPU_RESET;
			2: return RESET_PIN_OE_N;
			3: return CLK_EN.sys;
			default: return CLK_EN.osc;
		endcase
	endfunction
	// Bounded wait at falling edges; n is the number of cycles it took
	task automatic wt(input string nm, input int sel, input logic v, input int lim, output int n);
		n = 0;
		while (pick(sel) !== v && n < lim) begin
			@(negedge CLK_SYS);
			n++;
		end
		if (pick(sel) !== v) begin
			n_mismatch++;
			$display("unexpected %s expected %b seen %b", nm, v, pick(sel));
		end
	endtask
	// Load a mode, fetch a halt, then check the gated clocks
	task automatic enter(input logic [1:0] m, input logic d);
		CFG_IN = '{m, d};
		CFG_WR = 1'h1;
		@(negedge CLK_SYS);
		CFG_WR     = 1'h0;
		HALT_FETCH = 1'h1;
		@(negedge CLK_SYS);
		HALT_FETCH = 1'h0;
		@(negedge CLK_SYS);
		chk_en("clk_en_halt", EN_HALT[m], CLK_EN);
	endtask
	task automatic int_off();
		i_irq_reset_source.set_int(1'h1);
		repeat (6) @(negedge CLK_SYS);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Short pin reset stretched by the device, then dummy cycles
	task automatic t_reset_on();
		int n;
		i_irq_reset_source.reset_low(3);
		wt("cpu_reset_rise", 1, 1'h1, 12, n);
		chk_bit("oe_n", 1'h0, RESET_PIN_OE_N);
		chk_bit("pin_drive", 1'h0, RESET_PIN_OUT);
		wt("oe_n_release", 2, 1'h1, 30, n);
		chk_bit("stretch", 1'h1, n >= RST_STRETCH - 1 && n <= RST_STRETCH);
		wt("cpu_reset_fall", 1, 1'h0, 20, n);
		wt("start", 0, 1'h1, 8, n);
		chk_word("dummy", 16'(DUMMY_T_STATES), 16'(n));
		chk_word("addr", ADDR_RESET, START_ADDR);
		$display("done reset_on");
	endtask
	// Interrupt wake from both idle modes, one NOP then service
	task automatic t_idle();
		int n;
		for (int m = 0; m < 2; m++) begin
			enter(2'(m), 1'h0);
			i_irq_reset_source.set_int(1'h0);
			wt("sys_on", 3, 1'h1, 10, n);
			chk_bit("clk_out_on", 1'h1, CLK_EN.clk_out);
			wt("start", 0, 1'h1, 10, n);
			chk_word("nop_len", 16'(T4_INDEX + 1), 16'(n));
			chk_bit("svc_int", 1'h1, SERVICE_INT);
			chk_bit("halted", 1'h0, HALTED);
			int_off();
		end
		$display("done idle");
	endtask
	// Request gone before T4: clock starts, then stops again
	task automatic t_refuse();
		int n;
		logic seen;
		seen = 1'h0;
		enter(MODE_IDLE_ALL, 1'h0);
		i_irq_reset_source.set_int(1'h0);
		repeat (2) @(negedge CLK_SYS);
		i_irq_reset_source.set_int(1'h1);
		wt("sys_on", 3, 1'h1, 10, n);
		repeat (12) begin
			@(negedge CLK_SYS);
			if (START_FETCH === 1'h1) seen = 1'h1;
		end
		chk_bit("no_start", 1'h0, seen);
		chk_bit("sys_off", 1'h0, CLK_EN.sys);
		chk_bit("still_halted", 1'h1, HALTED);
		$display("done refuse");
	endtask
	// Both requests pending while idle: the non-maskable one wins
	task automatic t_nmi();
		int n;
		i_irq_reset_source.set_nmi(1'h0);
		i_irq_reset_source.set_int(1'h0);
		wt("start", 0, 1'h1, 16, n);
		chk_bit("svc_nmi", 1'h1, SERVICE_NMI);
		chk_bit("svc_int_lost", 1'h0, SERVICE_INT);
		chk_word("nmi_addr", ADDR_NMI, START_ADDR);
		i_irq_reset_source.set_nmi(1'h1);
		int_off();
		$display("done nmi");
	endtask
	// Interrupt out of stop: oscillator first, clocks after warm-up
	task automatic t_stop_int();
		int n;
		enter(MODE_STOP, 1'h0);
		i_irq_reset_source.set_int(1'h0);
		wt("osc_on", 4, 1'h1, 10, n);
		chk_bit("clk_out_warm", 1'h0, CLK_EN.clk_out);
		wt("sys_on", 3, 1'h1, W + 10, n);
		chk_bit("warm_len", 1'h1, n >= W && n <= W + 2);
		wt("start", 0, 1'h1, 8, n);
		chk_bit("svc_int", 1'h1, SERVICE_INT);
		int_off();
		$display("done stop_int");
	endtask
	// Reset out of stop: no warm-up, registers back to defaults
	task automatic t_stop_rst();
		int n;
		enter(MODE_STOP, 1'h0);
		i_irq_reset_source.reset_low(6);
		wt("osc_on", 4, 1'h1, 10, n);
		wt("start", 0, 1'h1, 60, n);
		chk_bit("no_warm", 1'h1, n < W);
		chk_word("cfg", 16'({HALT_MODE_RESET, RSTOUT_DIS_RESET}), 16'(CFG));
		$display("done stop_rst");
	endtask
	// Always-running halt: clocks stay on, interrupt releases
	task automatic t_run();
		int n;
		enter(MODE_RUN, 1'h0);
		chk_bit("halted", 1'h1, HALTED);
		i_irq_reset_source.set_int(1'h0);
		wt("start", 0, 1'h1, 12, n);
		chk_bit("svc_int", 1'h1, SERVICE_INT);
		int_off();
		$display("done run");
	endtask
	// Reset from idle with the pin drive disabled
	task automatic t_reset_off();
		int n;
		enter(MODE_IDLE_TIMER, 1'h1);
		i_irq_reset_source.reset_low(4);
		wt("cpu_reset_rise", 1, 1'h1, 12, n);
		chk_bit("sys_on", 1'h1, CLK_EN.sys);
		chk_bit("oe_n_off", 1'h1, RESET_PIN_OE_N);
		wt("cpu_reset_fall", 1, 1'h0, 30, n);
		wt("start", 0, 1'h1, 8, n);
		chk_word("addr", ADDR_RESET, START_ADDR);
		chk_word("cfg", 16'({HALT_MODE_RESET, RSTOUT_DIS_RESET}), 16'(CFG));
		$display("done reset_off");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		int n;
		RESET      = 1'h1;
		HALT_FETCH = 1'h0;
		CFG_WR     = 1'h0;
		CFG_IN     = '{MODE_RUN, 1'h0};
		repeat (4) @(negedge CLK_SYS);
		RESET = 1'h0;
		wt("first_start", 0, 1'h1, 20, n);
		t_reset_on();
		t_idle();
		t_refuse();
		t_nmi();
		t_stop_int();
		t_stop_rst();
		t_run();
		t_reset_off();
		wrap_up();
	end
endmodule
`default_nettype wire

// File: tb/irq_reset_source.sv
// Behavioural interrupt sources and external reset source facing the halt and wake control
`timescale 1ns/1ps
`default_nettype none
module irq_reset_source (
	// Clock that paces the pin changes
	input  wire logic CLK_SYS,
	// Reset pin drive from the device
	input  wire logic pin_drv,
	input  wire logic pin_oe_n,
	// Pins toward the device
	output var  logic nmi_n,
	output var  logic int_n,
	output var  logic reset_pin_n
);
	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	logic ext_low;
	// Pins idle high, nobody pulls the reset line
	initial begin
		nmi_n   = 1'h1;
		int_n   = 1'h1;
		ext_low = 1'h0;
	end
	// Open-drain line with pull-up: low while either side pulls it
	assign reset_pin_n = ~ext_low & (pin_oe_n | pin_drv);
	// Changes land on the falling edge, well clear of the sampling edge
	task automatic set_int(input logic lvl);
		@(negedge CLK_SYS);
		int_n = lvl;
	endtask
	task automatic set_nmi(input logic lvl);
		@(negedge CLK_SYS);
		nmi_n = lvl;
	endtask
	// Never shorter than three clocks, whatever the caller asks
	task automatic reset_low(input int n);
		int k;
		k = (n < 3) ? 3 : n;
		@(negedge CLK_SYS);
		ext_low = 1'h1;
		repeat (k) @(negedge CLK_SYS);
		ext_low = 1'h0;
	endtask
endmodule
`default_nettype wire
